//--- src/clu_pkg.sv
// constants, field layouts and types shared by the glue logic unit
// assumes a 32-bit apb bus with one register per aligned word
package clu_pkg;

  // ***********************************
  // register indices, byte address = 4 * index
  // ***********************************
  localparam int unsigned IDX_W       = 4;
  localparam logic [3:0]  IDX_GLOBAL  = 4'h0;
  localparam logic [3:0]  IDX_SEQ     = 4'h1;
  localparam logic [3:0]  IDX_L0_CTRL = 4'h5;
  localparam logic [3:0]  IDX_L0_SELL = 4'h6;
  localparam logic [3:0]  IDX_L0_SELH = 4'h7;
  localparam logic [3:0]  IDX_L0_TT   = 4'h8;
  localparam logic [3:0]  IDX_L1_CTRL = 4'h9;
  localparam logic [3:0]  IDX_L1_SELL = 4'hA;
  localparam logic [3:0]  IDX_L1_SELH = 4'hB;
  localparam logic [3:0]  IDX_L1_TT   = 4'hC;
  localparam logic [3:0]  IDX_STATUS  = 4'hD;
  localparam int unsigned IDX_LSB     = 2;

  // ***********************************
  // fields and reset values
  // ***********************************
  localparam int unsigned GLB_EN_BIT   = 0;
  localparam int unsigned GLB_KEEP_BIT = 6;
  localparam logic [7:0]  GLB_WMASK    = 8'h41;
  localparam logic [7:0]  CTRL_WMASK   = 8'hF9;
  localparam logic [7:0]  SEQ_WMASK    = 8'h0F;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam int unsigned SEL_W        = 4;
  localparam int unsigned SEL1_LSB     = 4;
  localparam int unsigned ST_SEQ_BIT   = 2;

  localparam logic [3:0] SEQ_OFF    = 4'h0;
  localparam logic [3:0] SEQ_DFF    = 4'h1;
  localparam logic [3:0] SEQ_JK     = 4'h2;
  localparam logic [3:0] SEQ_GATED_D_LATCH_MODE = 4'h3;
  localparam logic [3:0] SEQ_RS     = 4'h4;

  localparam logic [1:0] FILT_NONE   = 2'h0;
  localparam logic [1:0] FILT_SYNCHRONIZER_OPTION  = 2'h1;
  localparam logic [1:0] FILT_FILTER = 2'h2;

  localparam logic [3:0] SRC_MASK     = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK = 4'h1;
  localparam logic [3:0] SRC_LINK     = 4'h2;
  localparam logic [3:0] SRC_EVT_OWN  = 4'h3;
  localparam logic [3:0] SRC_EVT_ALT  = 4'h4;
  localparam logic [3:0] SRC_PIN      = 4'h5;
  localparam logic [3:0] SRC_PERIPH   = 4'h6;
  localparam logic [3:0] SRC_LAST     = 4'hE;

  // filter chain: taps for the synchronizer and the filter vote
  localparam int unsigned FILT_STAGES = 4;
  localparam int unsigned SYNCHRONIZER_OPTION_TAP   = 1;
  localparam int unsigned FILT_DLY_MIN = 2;
  localparam int unsigned FILT_DLY_MAX = 5;

  // table control byte, laid out as the register
  typedef struct packed {
    logic       edge_en;
    logic       clk_src;
    logic [1:0] filt_sel;
    logic       pin_oe;
    logic [1:0] rsvd;
    logic       enable;
  } clu_ctrl_t;

endpackage

//--- src/clu_table.sv
// one lookup table with output synchronizer, filter and edge detector
// assumes tick marks a rising edge of the selected table clock
`timescale 1ns/1ps
module clu_table
  import clu_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       en,
  input  wire logic       tick,
  input  wire logic [7:0] truth,
  input  wire logic [2:0] idx,
  input  wire logic [1:0] filt_sel,
  input  wire logic       edge_en,
  output logic            raw,
  output logic            proc
);

  logic [FILT_STAGES-1:0] stage_q, stage_d;
  logic                   filt_q, filt_d;
  logic                   prev_q, prev_d;
  logic                   pulse_q, pulse_d;
  logic                   filt_out;

  // decode runs unclocked, so it keeps going in idle sleep
  assign raw = truth[idx];

  // ***********************************
  // next state
  // ***********************************
  always_comb begin
    stage_d  = stage_q;
    filt_d   = filt_q;
    prev_d   = prev_q;
    pulse_d  = pulse_q;
    filt_out = raw;
    case (filt_sel)
      FILT_SYNCHRONIZER_OPTION:  filt_out = filt_q;
      FILT_FILTER: filt_out = filt_q;
      default:     filt_out = raw;
    endcase
    if (!en) begin
      // state drops on the first edge after disable
      stage_d = '0;
      filt_d  = 1'b0;
      prev_d  = 1'b0;
      pulse_d = 1'b0;
    end else if (tick) begin
      stage_d = {stage_q[FILT_STAGES-2:0], raw};
      if (filt_sel == FILT_SYNCHRONIZER_OPTION) begin
        filt_d = stage_q[SYNCHRONIZER_OPTION_TAP];
      end else if (stage_q[FILT_STAGES-1] == stage_q[FILT_STAGES-2] &&
                   stage_q[FILT_STAGES-2] == stage_q[FILT_STAGES-3]) begin
        // only a level seen three times running gets through
        filt_d = stage_q[FILT_STAGES-1];
      end
      prev_d  = filt_out;
      pulse_d = filt_out & ~prev_q;
    end
  end

  assign proc = edge_en ? pulse_q : filt_out;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stage_q <= '0;
      filt_q  <= 1'b0;
      prev_q  <= 1'b0;
      pulse_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      filt_q  <= filt_d;
      prev_q  <= prev_d;
      pulse_q <= pulse_d;
    end
  end

  // ***********************************
  // checks
  // ***********************************
  filt_clear_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !en |=> (stage_q == '0 && !filt_q && !pulse_q && !prev_q))
    else $error("filter state not cleared after disable");

  edge_once_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(pulse_q) |-> $past(en && tick && !prev_q))
    else $error("edge pulse without a rising sample");

  synchronizer_option_delay_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (en && tick && filt_sel == FILT_SYNCHRONIZER_OPTION) |=>
      filt_q == $past(stage_q[SYNCHRONIZER_OPTION_TAP]))
    else $error("synchronizer stage mismatch");

endmodule

//--- src/clu_top.sv
// glue logic unit: two lookup tables, shared sequential element, apb regs
// assumes apb master on core_clk; table pins come from outside the domain
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

module clu_top
  import clu_pkg::*;
#(
  parameter int unsigned APB_AW   = 12,
  parameter int unsigned N_PERIPH = 9
)(
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_AW-1:0]     paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  standby_sleep,
  input  wire logic                  event_line_a,
  input  wire logic                  event_line_b,
  input  wire logic [5:0]            table_input_pin,
  input  wire logic [N_PERIPH-1:0]   periph_in_0,
  input  wire logic [N_PERIPH-1:0]   periph_in_1,
  output logic      [1:0]            table_output,
  output logic      [1:0]            table_output_oe_n,
  output logic      [1:0]            table_output_event
);

  // ***********************************
  // register state
  // ***********************************
  logic [7:0]  glb_q, glb_d;
  logic [3:0]  sequential_function_select_q, sequential_function_select_d;
  logic [7:0]  ctrl_q [2];
  logic [7:0]  ctrl_d [2];
  logic [7:0]  sell_q [2];
  logic [7:0]  sell_d [2];
  logic [3:0]  selh_q [2];
  logic [3:0]  selh_d [2];
  logic [7:0]  tt_q [2];
  logic [7:0]  tt_d [2];
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;

  // ***********************************
  // datapath state
  // ***********************************
  logic [5:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_v_q, pin_v_d;
  logic [1:0] in2_prev_q, in2_prev_d;
  logic       seq_q, seq_d;
  logic [1:0] out_q, out_d;
  logic [1:0] oe_n_q, oe_n_d;
  logic [1:0] evt_q, evt_d;

  clu_ctrl_t  cfg [2];
  logic [1:0] tbl_en, tick, raw, proc, in2, frozen;
  logic [2:0] in_val [2];
  logic [2:0] idx [2];
  logic [3:0] wr_idx;
  logic       access, setup, mapped;

  assign cfg[0] = clu_ctrl_t'(ctrl_q[0]);
  assign cfg[1] = clu_ctrl_t'(ctrl_q[1]);
  // core clock stopped in standby unless kept running
  assign frozen[0] = standby_sleep & ~glb_q[GLB_KEEP_BIT];
  assign frozen[1] = frozen[0];

  // ***********************************
  // input source selection
  // ***********************************
  function automatic logic pick_src(
    input logic [3:0]          sel,
    input logic                n,
    input logic [1:0]          y,
    input logic                seq_fb,
    input logic                link,
    input logic [5:0]          pins,
    input logic [N_PERIPH-1:0] periph
  );
    logic [3:0] k;
    logic       v;
    k = sel - SRC_PERIPH;
    v = 1'b0;
    case (sel)
      SRC_MASK:     v = 1'b0;
      SRC_FEEDBACK: v = seq_fb;
      SRC_LINK:     v = link;
      // events are used unsampled
      SRC_EVT_OWN:  v = n ? event_line_b : event_line_a;
      SRC_EVT_ALT:  v = n ? event_line_a : event_line_b;
      SRC_PIN:      v = pins[3'(3 * n) + 3'(y)];
      default: begin
        if (sel >= SRC_PERIPH && sel <= SRC_LAST &&
            int'(k) < N_PERIPH) begin
          v = periph[k];
        end
      end
    endcase
    return v;
  endfunction

  always_comb begin
    for (int n = 0; n < 2; n++) begin
      in_val[n][0] = pick_src(sell_q[n][SEL_W-1:0], n[0], 2'd0, seq_q,
                              raw[1-n], pin_v_q,
                              n == 0 ? periph_in_0 : periph_in_1);
      in_val[n][1] = pick_src(sell_q[n][SEL1_LSB+:SEL_W], n[0], 2'd1,
                              seq_q, raw[1-n], pin_v_q,
                              n == 0 ? periph_in_0 : periph_in_1);
      in_val[n][2] = pick_src(selh_q[n], n[0], 2'd2, seq_q, raw[1-n],
                              pin_v_q, n == 0 ? periph_in_0 : periph_in_1);
      in2[n]    = in_val[n][2];
      // input 2 acting as clock reads as masked
      idx[n]    = {in_val[n][2] & ~cfg[n].clk_src, in_val[n][1:0]};
      tbl_en[n] = glb_q[GLB_EN_BIT] & cfg[n].enable;
      // selected clock as a rising-edge tick
      tick[n]   = cfg[n].clk_src ? (in2[n] & ~in2_prev_q[n]) : ~frozen[n];
    end
  end

  // ***********************************
  // lookup tables
  // ***********************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tbl
      clu_table u_tbl (
        .core_clk (core_clk),
        .rstn     (rstn),
        .en       (tbl_en[g]),
        .tick     (tick[g]),
        .truth    (tt_q[g]),
        .idx      (idx[g]),
        .filt_sel (cfg[g].filt_sel),
        .edge_en  (cfg[g].edge_en),
        .raw      (raw[g]),
        .proc     (proc[g])
      );
    end
  endgenerate

  // ***********************************
  // sequential element and outputs
  // ***********************************
  always_comb begin
    seq_d      = seq_q;
    in2_prev_d = in2;
    pin_v_d    = pin_v_q;
    for (int i = 0; i < 6; i++) begin
      if (pin_s2_q[i] == pin_s3_q[i]) begin
        pin_v_d[i] = pin_s3_q[i];
      end
    end
    if (!tbl_en[0]) begin
      seq_d = 1'b0;
    end else begin
      case (sequential_function_select_q)
        SEQ_DFF: begin
          if (tick[0] && proc[1]) begin
            seq_d = proc[0];
          end
        end
        SEQ_JK: begin
          if (tick[0]) begin
            case ({proc[0], proc[1]})
              2'b01:   seq_d = 1'b0;
              2'b10:   seq_d = 1'b1;
              2'b11:   seq_d = ~seq_q;
              default: seq_d = seq_q;
            endcase
          end
        end
        SEQ_GATED_D_LATCH_MODE: begin
          if (proc[1] && !frozen[0]) begin
            seq_d = proc[0];
          end
        end
        SEQ_RS: begin
          // both high is forbidden; hold is the safe answer
          if (proc[0] && !proc[1] && !frozen[0]) begin
            seq_d = 1'b1;
          end else if (!proc[0] && proc[1] && !frozen[0]) begin
            seq_d = 1'b0;
          end
        end
        default: seq_d = 1'b0;
      endcase
    end
    for (int n = 0; n < 2; n++) begin
      out_d[n] = 1'b0;
      if (tbl_en[n]) begin
        if (n == 0 && sequential_function_select_q != SEQ_OFF) begin
          out_d[n] = seq_q;
        end else begin
          out_d[n] = proc[n];
        end
        if (frozen[n] && !cfg[n].clk_src &&
            (cfg[n].filt_sel != FILT_NONE || cfg[n].edge_en ||
             sequential_function_select_q != SEQ_OFF)) begin
          out_d[n] = 1'b0;
        end
      end
      oe_n_d[n] = ~(tbl_en[n] & cfg[n].pin_oe);
    end
    evt_d = out_d;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pin_s1_q   <= '0;
      pin_s2_q   <= '0;
      pin_s3_q   <= '0;
      pin_v_q    <= '0;
      in2_prev_q <= '0;
      seq_q      <= 1'b0;
      out_q      <= '0;
      oe_n_q     <= '1;
      evt_q      <= '0;
    end else begin
      pin_s1_q   <= table_input_pin;
      pin_s2_q   <= pin_s1_q;
      pin_s3_q   <= pin_s2_q;
      pin_v_q    <= pin_v_d;
      in2_prev_q <= in2_prev_d;
      seq_q      <= seq_d;
      out_q      <= out_d;
      oe_n_q     <= oe_n_d;
      evt_q      <= evt_d;
    end
  end

  assign table_output       = out_q;
  assign table_output_oe_n  = oe_n_q;
  assign table_output_event = evt_q;

  // ***********************************
  // apb slave, zero wait in access phase
  // ***********************************
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_q;
  assign wr_idx = paddr[IDX_LSB+:IDX_W];
  assign mapped = (paddr[APB_AW-1:IDX_LSB+IDX_W] == '0) &&
                  (wr_idx <= IDX_SEQ ||
                   (wr_idx >= IDX_L0_CTRL && wr_idx <= IDX_STATUS));

  always_comb begin
    glb_d     = glb_q;
    sequential_function_select_d  = sequential_function_select_q;
    ctrl_d    = ctrl_q;
    sell_d    = sell_q;
    selh_d    = selh_q;
    tt_d      = tt_q;
    pready_d  = setup;
    pslverr_d = setup & ~mapped;
    prdata_d  = prdata_q;
    if (setup) begin
      prdata_d = '0;
      case (wr_idx)
        IDX_GLOBAL:  prdata_d[7:0] = glb_q;
        IDX_SEQ:     prdata_d[3:0] = sequential_function_select_q;
        IDX_L0_CTRL: prdata_d[7:0] = ctrl_q[0];
        IDX_L0_SELL: prdata_d[7:0] = sell_q[0];
        IDX_L0_SELH: prdata_d[3:0] = selh_q[0];
        IDX_L0_TT:   prdata_d[7:0] = tt_q[0];
        IDX_L1_CTRL: prdata_d[7:0] = ctrl_q[1];
        IDX_L1_SELL: prdata_d[7:0] = sell_q[1];
        IDX_L1_SELH: prdata_d[3:0] = selh_q[1];
        IDX_L1_TT:   prdata_d[7:0] = tt_q[1];
        IDX_STATUS:  prdata_d[ST_SEQ_BIT:0] = {seq_q, out_q};
        default:     prdata_d = '0;
      endcase
    end
    if (access && pwrite && !pslverr_q) begin
      case (wr_idx)
        IDX_GLOBAL: glb_d = pwdata[7:0] & GLB_WMASK;
        IDX_SEQ: begin
          if (!cfg[0].enable) begin
            sequential_function_select_d = pwdata[3:0];
          end
        end
        IDX_L0_CTRL, IDX_L1_CTRL: begin
          // while enabled only the enable bit may change
          if (!cfg[wr_idx == IDX_L1_CTRL].enable) begin
            ctrl_d[wr_idx == IDX_L1_CTRL] = pwdata[7:0] & CTRL_WMASK;
          end else begin
            ctrl_d[wr_idx == IDX_L1_CTRL][0] = pwdata[0];
          end
        end
        IDX_L0_SELL, IDX_L1_SELL: begin
          if (!cfg[wr_idx == IDX_L1_SELL].enable) begin
            sell_d[wr_idx == IDX_L1_SELL] = pwdata[7:0];
          end
        end
        IDX_L0_SELH, IDX_L1_SELH: begin
          if (!cfg[wr_idx == IDX_L1_SELH].enable) begin
            selh_d[wr_idx == IDX_L1_SELH] = pwdata[SEL_W-1:0];
          end
        end
        IDX_L0_TT: tt_d[0] = pwdata[7:0];
        IDX_L1_TT: tt_d[1] = pwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      glb_q     <= REG_RESET;
      sequential_function_select_q  <= SEQ_OFF;
      ctrl_q    <= '{REG_RESET, REG_RESET};
      sell_q    <= '{REG_RESET, REG_RESET};
      selh_q    <= '{SRC_MASK, SRC_MASK};
      tt_q      <= '{REG_RESET, REG_RESET};
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      glb_q     <= glb_d;
      sequential_function_select_q  <= sequential_function_select_d;
      ctrl_q    <= ctrl_d;
      sell_q    <= sell_d;
      selh_q    <= selh_d;
      tt_q      <= tt_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ***********************************
  // checks
  // ***********************************
  seq_clear_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !tbl_en[0] |=> !seq_q)
    else $error("sequential element not cleared");

  jk_toggle_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (tbl_en[0] && sequential_function_select_q == SEQ_JK && tick[0] && proc[0] && proc[1])
      |=> seq_q != $past(seq_q))
    else $error("jk toggle missed");

  dff_hold_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (tbl_en[0] && sequential_function_select_q == SEQ_DFF && !tick[0]) |=> $stable(seq_q))
    else $error("flop changed without a clock tick");

  rs_set_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (tbl_en[0] && sequential_function_select_q == SEQ_RS && proc[0] && !proc[1] && !frozen[0])
      |=> seq_q)
    else $error("rs latch did not set");

  mask_in2_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    cfg[0].clk_src |-> !idx[0][2])
    else $error("input 2 used while clocking");

  standby_zero_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (frozen[0] && !cfg[0].clk_src && cfg[0].filt_sel != FILT_NONE)
      |=> !table_output[0])
    else $error("clocked table output not forced low");

  apb_ready_a: assert property (
    @(posedge core_clk) disable iff (!rstn)
    setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

endmodule

//--- verification/clu_far_model.sv
// far side: peripheral lines, event lines and pins feeding the tables
// assumes the bench sets a 4-bit level code just after a clock edge
`timescale 1ns/1ps
module clu_far_model
  import clu_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic [3:0] lvl,
  output logic      [8:0] periph_a,
  output logic      [8:0] periph_b,
  output logic            evt_a,
  output logic            evt_b,
  output logic      [5:0] pins
);
  // ***********************************
  // registered sources, one edge behind the code
  // ***********************************
  always_ff @(posedge core_clk) begin
    periph_a <= {6'h00, lvl[2:0]};
    periph_b <= {8'h00, lvl[3]};
    evt_a    <= lvl[0];
    evt_b    <= lvl[3];
    pins     <= {3'h0, lvl[2:0]};
  end
endmodule

//--- verification/clu_top_tb.sv
// self-checking bench for the glue logic unit
// assumes clu_top with default parameters and the far side model
`timescale 1ns/1ps
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    mismatches++; \
    $display("BAD t=%0t got %h exp %h", $time, a, b); \
  end \
end
module clu_top_tb;
  import clu_pkg::*;
  logic        core_clk, rstn, psel, penable, pwrite, standby_sleep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, evt_a, evt_b, err;
  logic [5:0]  pins;
  logic [8:0]  per_a, per_b;
  logic [1:0]  tout, toe_n, tevt;
  logic [3:0]  lvl;
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  clu_far_model far_u (.core_clk(core_clk), .lvl(lvl), .periph_a(per_a),
    .periph_b(per_b), .evt_a(evt_a), .evt_b(evt_b), .pins(pins));
  clu_top dut_u (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .standby_sleep(standby_sleep), .event_line_a(evt_a),
    .event_line_b(evt_b), .table_input_pin(pins), .periph_in_0(per_a),
    .periph_in_1(per_b), .table_output(tout), .table_output_oe_n(toe_n),
    .table_output_event(tevt));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ***********************************
  // closing and hang guard
  // ***********************************
  task automatic test_done();
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  // ***********************************
  // bus helpers
  // ***********************************
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  task automatic apb(input logic w, input logic [3:0] i,
                     input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {6'h00, i, 2'h0};
    pwdata  <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // no wait limit here: only the bench timeout ends a hung transfer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask

  // protected fields only change while the table is off
  task automatic cfg(input logic [3:0] b, input logic [7:0] ctl, tt, sl,
                     sh);
    wr(b, 8'h00);
    wr(b + 4'h1, sl);
    wr(b + 4'h2, sh);
    wr(b + 4'h3, tt);
    wr(b, ctl);
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  task automatic s_regs();
    logic [3:0] idx [10] = '{4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                             4'hA, 4'hB, 4'hC};
    foreach (idx[j]) begin
      apb(1'b0, idx[j], 8'h00);
      `CHK(rd, 32'h0000_0000)
    end
    apb(1'b0, 4'h2, 8'h00);
    `CHK(err, 1'b1)
    wr(IDX_SEQ, 8'hFF);
    apb(1'b0, IDX_SEQ, 8'h00);
    `CHK(rd, 32'h0000_000F)
    wr(IDX_SEQ, 8'h00);
    wr(IDX_GLOBAL, 8'h01);
  endtask

  task automatic s_decode();
    logic [7:0] tt;
    tt = 8'hA6;
    cfg(IDX_L0_CTRL, 8'h01, tt, 8'h76, 8'h08);
    for (int i = 0; i < 8; i++) begin
      lvl <= 4'(i);
      cyc(4);
      `CHK(tevt[0], tt[i])
    end
    wr(IDX_GLOBAL, 8'h00);
    cfg(IDX_L0_CTRL, 8'h41, tt, 8'h76, 8'h08);
    wr(IDX_GLOBAL, 8'h01);
    lvl <= 4'h7;
    cyc(4);
    `CHK(tevt[0], tt[3])
    wr(IDX_GLOBAL, 8'h00);
    wr(IDX_L0_CTRL, 8'h00);
    wr(IDX_GLOBAL, 8'h01);
  endtask

  task automatic s_io();
    cfg(IDX_L0_CTRL, 8'h01, 8'hAA, 8'h03, 8'h00);
    cfg(IDX_L1_CTRL, 8'h01, 8'hAA, 8'h03, 8'h00);
    lvl <= 4'h1;
    cyc(3);
    `CHK(tevt, 2'b01)
    lvl <= 4'h8;
    cyc(3);
    `CHK(tevt, 2'b10)
    cfg(IDX_L0_CTRL, 8'h09, 8'hAA, 8'h05, 8'h00);
    lvl <= 4'h1;
    cyc(9);
    `CHK({tout[0], toe_n[0]}, 2'b10)
  endtask

  task automatic s_seq();
    logic ev;
    logic od;
    cfg(IDX_L1_CTRL, 8'h01, 8'hAA, 8'h06, 8'h00);
    for (int m = 1; m < 5; m++) begin
      cfg(IDX_L0_CTRL, 8'h00, 8'hAA, 8'h06, 8'h00);
      wr(IDX_SEQ, 8'(m));
      wr(IDX_L0_CTRL, 8'h01);
      for (int k = 0; k < 3; k++) begin
        ev = (k == 1);
        od = (k == 0) || (k == 1 && m[0]);
        lvl <= {od, 2'h0, ev};
        cyc(8);
        `CHK(tevt[0], k > 0)
      end
      if (m == 2) begin
        // one tick of j and k both high flips the held one to zero
        lvl <= 4'h9;
        cyc(1);
        lvl <= 4'h0;
        cyc(8);
        `CHK(tevt[0], 1'b0)
      end
      wr(IDX_L0_CTRL, 8'h00);
      apb(1'b0, IDX_STATUS, 8'h00);
      `CHK(rd[ST_SEQ_BIT], 1'b0)
    end
    wr(IDX_SEQ, 8'h00);
  endtask

  task automatic s_filt();
    cfg(IDX_L0_CTRL, 8'h21, 8'hAA, 8'h06, 8'h00);
    lvl <= 4'h0;
    cyc(10);
    lvl <= 4'h1;
    cyc(4);
    `CHK(tevt[0], 1'b0)
    cyc(8);
    `CHK(tevt[0], 1'b1)
    standby_sleep <= 1'b1;
    cyc(4);
    `CHK(tevt[0], 1'b0)
    wr(IDX_GLOBAL, 8'h41);
    cyc(4);
    `CHK(tevt[0], 1'b1)
    standby_sleep <= 1'b0;
    wr(IDX_GLOBAL, 8'h01);
  endtask

  task automatic s_edge();
    int n;
    cfg(IDX_L0_CTRL, 8'h91, 8'hAA, 8'h06, 8'h00);
    for (int p = 1; p >= 0; p--) begin
      lvl <= 4'(1 - p);
      cyc(12);
      lvl <= 4'(p);
      n = 0;
      repeat (16) begin
        @(posedge core_clk);
        if (tevt[0] !== 1'b0)
          n++;
      end
      `CHK(n, p)
    end
  endtask

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    standby_sleep = 1'b0;
    lvl = 4'h0;
    cyc(5);
    rstn <= 1'b1;
    s_regs();
    s_decode();
    s_io();
    s_seq();
    s_filt();
    s_edge();
    test_done();
  end
endmodule
